// ### design/cmp_ctrl.sv
// dual analog comparator control and status logic with a wishbone slave
`timescale 1ns/1ps
module cmp_ctrl #(
   parameter bit FULL_PINS = 1'b1
) (
   // clock, reset, enable
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // analog side
   input wire logic [1:0] cmp_raw_i,
   output logic [1:0] cmp_power_o,
   output logic [1:0] pos_source_select_o,
   output logic [3:0] negative_channel_select_o,
   // result output pins, index 0 first pin
   input wire logic [1:0] port_latch_i,
   input wire logic [1:0] port_direction_bits_i,
   output logic [1:0] result_output_pin_o,
   output logic [1:0] result_output_pin_oe_o,
   // power state and interrupt
   input wire logic sleep_i,
   output logic irq_o,
   output logic wake_o
);

   // availability of a negative channel code per comparator
   function automatic logic chan_ok(input logic idx, input logic [1:0] code);
      logic ok;
      ok = 1'b1;
      if (code == cmp_ctrl_pkg::NEG_THIRD) begin
         ok = FULL_PINS;
      end
      if (code == cmp_ctrl_pkg::NEG_FOURTH) begin
         ok = FULL_PINS && idx;
      end
      return ok;
   endfunction : chan_ok

   // event hit for an edge mode
   function automatic logic edge_hit(input logic [1:0] mode, input logic now,
                                     input logic prev);
      logic hit;
      hit = 1'b0;
      case (mode)
         cmp_ctrl_pkg::EDGE_RISE: hit = now && !prev;
         cmp_ctrl_pkg::EDGE_FALL: hit = !now && prev;
         cmp_ctrl_pkg::EDGE_ANY: hit = now != prev;
         default: hit = 1'b0;
      endcase
      return hit;
   endfunction : edge_hit

   logic [7:0] ctrl_q [2];
   logic [1:0] flag_q;
   logic [1:0] irq_en_q;
   logic periph_en_q;
   logic global_en_q;
   logic [1:0] sync1_q;
   logic [1:0] sync2_q;
   logic [1:0] adj_prev_q;
   logic [1:0] adj;
   logic [1:0] hw_set;
   logic [1:0] auto_set;
   logic ack_q;
   logic [31:0] rdata_q;
   logic req;
   logic wr;
   logic wr_ctrl1;
   logic wr_ctrl2;
   logic wr_flags;
   logic wr_enables;
   logic wr_intctl;
   logic [31:0] rdata_d;
   logic [1:0] req_pend;

   // bus decode
   assign req = wb_cyc_i && wb_stb_i && !ack_q;
   assign wr = req && wb_we_i && wb_sel_i[0];
   assign wr_ctrl1 = wr && wb_adr_i == cmp_ctrl_pkg::OFS_CTRL1;
   assign wr_ctrl2 = wr && wb_adr_i == cmp_ctrl_pkg::OFS_CTRL2;
   assign wr_flags = wr && wb_adr_i == cmp_ctrl_pkg::OFS_FLAGS;
   assign wr_enables = wr && wb_adr_i == cmp_ctrl_pkg::OFS_ENABLES;
   assign wr_intctl = wr && wb_adr_i == cmp_ctrl_pkg::OFS_INTCTL;

   // control registers, unavailable channel codes keep the old field
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q[0] <= cmp_ctrl_pkg::CTRL_RESET;
         ctrl_q[1] <= cmp_ctrl_pkg::CTRL_RESET;
      end else if (ce_i) begin
         if (wr_ctrl1) begin
            ctrl_q[0][7:2] <= wb_dat_i[7:2];
            if (chan_ok(1'b0, wb_dat_i[1:0])) begin
               ctrl_q[0][1:0] <= wb_dat_i[1:0];
            end
         end
         if (wr_ctrl2) begin
            ctrl_q[1][7:2] <= wb_dat_i[7:2];
            if (chan_ok(1'b1, wb_dat_i[1:0])) begin
               ctrl_q[1][1:0] <= wb_dat_i[1:0];
            end
         end
      end
   end

   // enable registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_en_q <= 2'h0;
         periph_en_q <= 1'b0;
         global_en_q <= 1'b0;
      end else if (ce_i) begin
         if (wr_enables) begin
            irq_en_q <= {wb_dat_i[cmp_ctrl_pkg::BIT_FLAG2], wb_dat_i[cmp_ctrl_pkg::BIT_FLAG1]};
         end
         if (wr_intctl) begin
            periph_en_q <= wb_dat_i[cmp_ctrl_pkg::BIT_PERIPH_EN];
            global_en_q <= wb_dat_i[cmp_ctrl_pkg::BIT_GLOBAL_EN];
         end
      end
   end

   // two-flop synchroniser and previous adjusted value
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync1_q <= 2'h0;
         sync2_q <= 2'h0;
         adj_prev_q <= 2'h0;
      end else if (ce_i) begin
         sync1_q <= cmp_raw_i;
         sync2_q <= sync1_q;
         adj_prev_q <= adj;
      end
   end

   // polarity-adjusted result; an unpowered comparator reads low before inversion
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         adj[i] = (sync2_q[i] && ctrl_q[i][cmp_ctrl_pkg::BIT_POWER])
                  ^ ctrl_q[i][cmp_ctrl_pkg::BIT_INVERT];
      end
   end

   // event detection, also while asleep
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         hw_set[i] = edge_hit(ctrl_q[i][4:3], adj[i], adj_prev_q[i]);
      end
   end

   // selecting an event mode sets the flag
   assign auto_set[0] = wr_ctrl1 && wb_dat_i[4:3] != cmp_ctrl_pkg::EDGE_NONE;
   assign auto_set[1] = wr_ctrl2 && wb_dat_i[4:3] != cmp_ctrl_pkg::EDGE_NONE;

   // sticky flags, any set beats a software clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flag_q <= 2'h0;
      end else if (ce_i) begin
         if (wr_flags) begin
            flag_q <= {wb_dat_i[cmp_ctrl_pkg::BIT_FLAG2], wb_dat_i[cmp_ctrl_pkg::BIT_FLAG1]}
                      | hw_set | auto_set;
         end else begin
            flag_q <= flag_q | hw_set | auto_set;
         end
      end
   end

   // interrupt request and wake
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
         wake_o <= 1'b0;
      end else if (ce_i) begin
         irq_o <= |(flag_q & irq_en_q) && periph_en_q && global_en_q;
         wake_o <= sleep_i && |(flag_q & irq_en_q) && periph_en_q;
      end
   end

   // read mux
   always_comb begin
      rdata_d = 32'h0000_0000;
      case (wb_adr_i)
         cmp_ctrl_pkg::OFS_CTRL1: rdata_d[7:0] = ctrl_q[0];
         cmp_ctrl_pkg::OFS_CTRL2: rdata_d[7:0] = ctrl_q[1];
         cmp_ctrl_pkg::OFS_STATUS: rdata_d[1:0] = adj;
         cmp_ctrl_pkg::OFS_FLAGS: begin
            rdata_d[cmp_ctrl_pkg::BIT_FLAG1] = flag_q[0];
            rdata_d[cmp_ctrl_pkg::BIT_FLAG2] = flag_q[1];
         end
         cmp_ctrl_pkg::OFS_ENABLES: begin
            rdata_d[cmp_ctrl_pkg::BIT_FLAG1] = irq_en_q[0];
            rdata_d[cmp_ctrl_pkg::BIT_FLAG2] = irq_en_q[1];
         end
         cmp_ctrl_pkg::OFS_INTCTL: begin
            rdata_d[cmp_ctrl_pkg::BIT_PERIPH_EN] = periph_en_q;
            rdata_d[cmp_ctrl_pkg::BIT_GLOBAL_EN] = global_en_q;
         end
         default: rdata_d = 32'h0000_0000;
      endcase
   end

   // one-cycle ack, read data registered with it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
      end else if (ce_i) begin
         ack_q <= req;
         if (req) begin
            rdata_q <= rdata_d;
         end
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdata_q;

   // analog routing
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         cmp_power_o[i] = ctrl_q[i][cmp_ctrl_pkg::BIT_POWER];
         pos_source_select_o[i] = ctrl_q[i][cmp_ctrl_pkg::BIT_POS_SEL];
      end
      negative_channel_select_o = {ctrl_q[1][1:0], ctrl_q[0][1:0]};
   end

   // pins: comparator 1 on the second pin, comparator 2 on the first
   always_comb begin
      req_pend[1] = ctrl_q[0][cmp_ctrl_pkg::BIT_ROUTE];
      req_pend[0] = ctrl_q[1][cmp_ctrl_pkg::BIT_ROUTE];
      result_output_pin_o[1] = req_pend[1] ? adj[0] : port_latch_i[1];
      result_output_pin_o[0] = req_pend[0] ? adj[1] : port_latch_i[0];
      result_output_pin_oe_o = port_direction_bits_i;
   end

   chk_status_upper: assert property (
      @(posedge clk_i) disable iff (rst_i)
      ce_i && req && wb_adr_i == cmp_ctrl_pkg::OFS_STATUS
      |=> wb_ack_o && wb_dat_o[31:2] == 30'h0 && wb_dat_o[1:0] == $past(adj))
      else $error("status read data wrong");

   chk_sync_delay: assert property (
      @(posedge clk_i) disable iff (rst_i)
      !rst_i && ce_i ##1 ce_i |=> sync2_q == $past(cmp_raw_i, 2))
      else $error("synchroniser delay wrong");

   chk_rise_flag: assert property (
      @(posedge clk_i) disable iff (rst_i)
      ce_i && ctrl_q[0][4:3] == cmp_ctrl_pkg::EDGE_RISE && adj[0] && !adj_prev_q[0]
      |=> flag_q[0])
      else $error("rising edge did not set flag");

   chk_fall_flag: assert property (
      @(posedge clk_i) disable iff (rst_i)
      ce_i && ctrl_q[1][4:3] == cmp_ctrl_pkg::EDGE_FALL && !adj[1] && adj_prev_q[1]
      |=> flag_q[1])
      else $error("falling edge did not set flag");

   chk_any_flag: assert property (
      @(posedge clk_i) disable iff (rst_i)
      ce_i && ctrl_q[0][4:3] == cmp_ctrl_pkg::EDGE_ANY && $changed(adj[0]) && !$past(rst_i)
      |=> flag_q[0])
      else $error("change did not set flag");

   chk_none_quiet: assert property (
      @(posedge clk_i) disable iff (rst_i)
      ce_i && ctrl_q[0][4:3] == cmp_ctrl_pkg::EDGE_NONE && !flag_q[0]
      && !wr_flags && !wr_ctrl1 |=> !flag_q[0])
      else $error("flag set with events off");

   chk_auto_flag: assert property (
      @(posedge clk_i) disable iff (rst_i)
      ce_i && wr_ctrl2 && wb_dat_i[4:3] != cmp_ctrl_pkg::EDGE_NONE |=> flag_q[1])
      else $error("mode select did not set flag");

   chk_irq_gate: assert property (
      @(posedge clk_i) disable iff (rst_i)
      irq_o |-> $past(global_en_q) && $past(periph_en_q) && $past(|(flag_q & irq_en_q)))
      else $error("request without all enables");

   chk_reset_ctrl: assert property (
      @(posedge clk_i)
      $past(rst_i) && !rst_i |-> ctrl_q[0] == cmp_ctrl_pkg::CTRL_RESET
      && ctrl_q[1] == cmp_ctrl_pkg::CTRL_RESET && cmp_power_o == 2'h0)
      else $error("control not reset");

   chk_off_result: assert property (
      @(posedge clk_i) disable iff (rst_i)
      !cmp_power_o[1] |-> adj[1] == ctrl_q[1][cmp_ctrl_pkg::BIT_INVERT])
      else $error("unpowered comparator result not idle");

   chk_pin_route: assert property (
      @(posedge clk_i) disable iff (rst_i)
      ctrl_q[0][cmp_ctrl_pkg::BIT_ROUTE] |-> result_output_pin_o[1] == adj[0])
      else $error("routed pin does not follow result");

   chk_pin2_route: assert property (
      @(posedge clk_i) disable iff (rst_i)
      ctrl_q[1][cmp_ctrl_pkg::BIT_ROUTE] |-> result_output_pin_o[0] == adj[1])
      else $error("first pin does not follow second result");

   chk_pin_latch: assert property (
      @(posedge clk_i) disable iff (rst_i)
      !ctrl_q[0][cmp_ctrl_pkg::BIT_ROUTE] |-> result_output_pin_o[1] == port_latch_i[1])
      else $error("unrouted pin does not show latch");

   chk_oe_follow: assert property (
      @(posedge clk_i) disable iff (rst_i)
      result_output_pin_oe_o == port_direction_bits_i)
      else $error("pin enable not taken from port direction");

   chk_flag_sticky: assert property (
      @(posedge clk_i) disable iff (rst_i)
      !rst_i && ce_i && flag_q[0] && !wr_flags |=> flag_q[0])
      else $error("flag cleared without software");

   chk_soft_set: assert property (
      @(posedge clk_i) disable iff (rst_i)
      !rst_i && ce_i && wr_flags && wb_dat_i[cmp_ctrl_pkg::BIT_FLAG2] |=> flag_q[1])
      else $error("software write did not set flag");

   chk_absent_chan: assert property (
      @(posedge clk_i) disable iff (rst_i)
      !rst_i && ce_i && wr_ctrl1 && wb_dat_i[1:0] == cmp_ctrl_pkg::NEG_FOURTH
      |=> ctrl_q[0][1:0] == $past(ctrl_q[0][1:0]))
      else $error("absent channel code was stored");

   chk_irq_raise: assert property (
      @(posedge clk_i) disable iff (rst_i)
      !rst_i && ce_i && global_en_q && periph_en_q && flag_q[0] && irq_en_q[0] |=> irq_o)
      else $error("enabled flag gave no request");

endmodule : cmp_ctrl

// ### design/cmp_ctrl_pkg.sv
// constants and register map of the dual comparator control block
// Notes on behaviour
// - power bit 7 runs comparator, clear turns off
// - route bit 6 puts result on pin
// - port direction keeps output enable; crossed pins
// - result high when positive exceeds negative input
// - edge field 11 flags every change
// - 01 flags rising, 10 flags falling edges
// - bit 2 picks ladder or first pin
// - bits 1-0 pick negative source
// - status holds both results, upper bits zero
// - sticky flags, software write one sets
// - request needs all three enables set
// - selecting event mode sets flag automatically
// - unavailable channels absent on reduced variants
// - keeps running asleep, interrupt wakes device
// - reset returns control registers to reset
package cmp_ctrl_pkg;
   localparam logic [7:0] OFS_CTRL1 = 8'h00;
   localparam logic [7:0] OFS_CTRL2 = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_FLAGS = 8'h0C;
   localparam logic [7:0] OFS_ENABLES = 8'h10;
   localparam logic [7:0] OFS_INTCTL = 8'h14;
   localparam int BIT_POWER = 7;
   localparam int BIT_ROUTE = 6;
   localparam int BIT_INVERT = 5;
   localparam int BIT_EDGE_HI = 4;
   localparam int BIT_EDGE_LO = 3;
   localparam int BIT_POS_SEL = 2;
   localparam int BIT_NEG_HI = 1;
   localparam int BIT_NEG_LO = 0;
   localparam int BIT_FLAG1 = 5;
   localparam int BIT_FLAG2 = 6;
   localparam int BIT_PERIPH_EN = 6;
   localparam int BIT_GLOBAL_EN = 7;
   localparam logic [7:0] CTRL_RESET = 8'h1F;
   localparam logic [1:0] EDGE_NONE = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_FALL = 2'h2;
   localparam logic [1:0] EDGE_ANY = 2'h3;
   localparam logic [1:0] NEG_SECOND = 2'h0;
   localparam logic [1:0] NEG_THIRD = 2'h1;
   localparam logic [1:0] NEG_FOURTH = 2'h2;
   localparam logic [1:0] NEG_FIXED_REF = 2'h3;
endpackage : cmp_ctrl_pkg

// ### test/analog_side_model.sv
// behavioural model of the analog inputs and the two comparators
`timescale 1ns/1ps
module analog_side_model #(
   parameter logic [7:0] FIXED_REF = 8'h40
) (
   // clock
   input wire logic clk_i,
   // controls from the block
   input wire logic [1:0] power_i,
   input wire logic [1:0] pos_sel_i,
   input wire logic [3:0] neg_sel_i,
   // levels: comparator c, pin p at [c*32+p*8 +: 8]
   input wire logic [7:0] ladder_i,
   input wire logic [63:0] pins_i,
   // raw results
   output logic [1:0] raw_o
);
   logic [1:0] junk_q = 2'h1;
   // an unpowered comparator gives no steady level
   always @(posedge clk_i) begin
      junk_q <= ~junk_q;
   end
   always_comb begin
      for (int c = 0; c < 2; c++) begin
         logic [7:0] vp;
         logic [7:0] vn;
         vp = pos_sel_i[c] ? ladder_i : pins_i[c*32 +: 8];
         vn = (neg_sel_i[2*c +: 2] == 2'h3) ? FIXED_REF
            : pins_i[c*32 + 8*(int'(neg_sel_i[2*c +: 2]) + 1) +: 8];
         raw_o[c] = power_i[c] ? (vp > vn) : junk_q[c];
      end
   end
endmodule : analog_side_model

// ### test/tb_top.sv
// self-checking testbench of the comparator control block
`timescale 1ns/1ps
module tb_top;
   typedef struct {logic [7:0] ctrl; logic [31:0] lv; logic res;} row_t;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic [31:0] rd;
   logic [31:0] rdat_r;
   logic [31:0] rd_r;
   logic ack;
   logic [1:0] raw, pwr, psel, pin, oe;
   logic [1:0] latch = 2'h1;
   logic [1:0] dir = 2'h3;
   logic [3:0] nsel;
   logic sleep = 1'b0;
   logic irq, wake;
   logic [7:0] ladder = 8'h50;
   logic [63:0] pins = 64'h0;
   int fails = 0;
   int num_checks = 0;
   row_t rows[8] = '{'{8'h80, 32'h00002030, 1'b1}, '{8'hC0, 32'h00002010, 1'b0},
      '{8'h81, 32'h00204030, 1'b1}, '{8'h82, 32'h40202030, 1'b0},
      '{8'h83, 32'h5A5A5A46, 1'b1}, '{8'h84, 32'h00004610, 1'b1},
      '{8'hE0, 32'h00002030, 1'b0}, '{8'h00, 32'h00002030, 1'b0}};

   cmp_ctrl i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(cyc),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .cmp_raw_i(raw), .cmp_power_o(pwr), .pos_source_select_o(psel),
      .negative_channel_select_o(nsel), .port_latch_i(latch), .port_direction_bits_i(dir),
      .result_output_pin_o(pin), .result_output_pin_oe_o(oe), .sleep_i(sleep), .irq_o(irq),
      .wake_o(wake));
   cmp_ctrl #(.FULL_PINS(1'b0)) i_red (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
      .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
      .wb_dat_i(wdat), .wb_dat_o(rdat_r), .wb_ack_o(), .cmp_raw_i(raw), .cmp_power_o(),
      .pos_source_select_o(), .negative_channel_select_o(), .port_latch_i(latch),
      .port_direction_bits_i(dir), .result_output_pin_o(), .result_output_pin_oe_o(),
      .sleep_i(sleep), .irq_o(), .wake_o());
   analog_side_model i_ana (.clk_i(clk_i), .power_i(pwr), .pos_sel_i(psel), .neg_sel_i(nsel),
      .ladder_i(ladder), .pins_i(pins), .raw_o(raw));

   initial begin
      forever #2 clk_i = ~clk_i;
   end

   task automatic stop_test;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : stop_test

   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("BAD at %0t reg got %h exp %h", $time, got, exp);
      end
   endtask : chk_reg

   task automatic chk_pin(input logic [1:0] got, input logic [1:0] exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("BAD at %0t pin got %h exp %h", $time, got, exp);
      end
   endtask : chk_pin

   task automatic waitc(input int n);
      repeat (n) @(posedge clk_i);
   endtask : waitc

   // one classic cycle, held until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      @(posedge clk_i);
      while (ack !== 1'b1 && n < 100) begin
         @(posedge clk_i);
         n++;
      end
      if (n == 100) begin
         fails++;
      end
      rd = rdat;
      rd_r = rdat_r;
      cyc <= 1'b0;
      @(posedge clk_i);
   endtask : wb

   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      chk_reg(rd, e);
   endtask : rchk

   initial begin
      #20000;
      fails++;
      stop_test();
   end

   initial begin
      waitc(3);
      rst_i <= 1'b0;
      waitc(1);
      rchk(cmp_ctrl_pkg::OFS_CTRL1, 32'h1F);
      rchk(cmp_ctrl_pkg::OFS_CTRL2, 32'h1F);
      chk_pin(pwr, 2'h0);
      chk_pin(psel, 2'h3);
      chk_reg({28'h0, nsel}, 32'hF);
      $display("reset test done");
      foreach (rows[i]) begin
         pins[63:32] <= rows[i].lv;
         wb(1'b1, cmp_ctrl_pkg::OFS_CTRL2, {24'h0, rows[i].ctrl});
         waitc(4);
         rchk(cmp_ctrl_pkg::OFS_STATUS, {30'h0, rows[i].res, 1'b0});
         chk_pin({1'b0, pin[0]}, {1'b0, rows[i].ctrl[6] ? rows[i].res : latch[0]});
      end
      rchk(cmp_ctrl_pkg::OFS_FLAGS, 32'h0);
      $display("table test done");
      for (int e = 1; e < 4; e++) begin
         pins[15:0] <= 16'h2010;
         wb(1'b1, cmp_ctrl_pkg::OFS_CTRL1, {24'h0, 8'h80 | 8'(e << 3)});
         waitc(4);
         rchk(cmp_ctrl_pkg::OFS_FLAGS, 32'h20);
         wb(1'b1, cmp_ctrl_pkg::OFS_FLAGS, 32'h0);
         pins[7:0] <= 8'h30;
         waitc(4);
         rchk(cmp_ctrl_pkg::OFS_FLAGS, e[0] ? 32'h20 : 32'h0);
         rchk(cmp_ctrl_pkg::OFS_STATUS, 32'h1);
         wb(1'b1, cmp_ctrl_pkg::OFS_FLAGS, 32'h0);
         pins[7:0] <= 8'h10;
         waitc(4);
         rchk(cmp_ctrl_pkg::OFS_FLAGS, e[1] ? 32'h20 : 32'h0);
      end
      $display("edge test done");
      wb(1'b1, cmp_ctrl_pkg::OFS_ENABLES, 32'h20);
      wb(1'b1, cmp_ctrl_pkg::OFS_INTCTL, 32'h40);
      chk_pin({irq, wake}, 2'h0);
      sleep <= 1'b1;
      waitc(2);
      chk_pin({irq, wake}, 2'h1);
      wb(1'b1, cmp_ctrl_pkg::OFS_INTCTL, 32'hC0);
      waitc(2);
      chk_pin({irq, wake}, 2'h3);
      wb(1'b1, cmp_ctrl_pkg::OFS_FLAGS, 32'h0);
      waitc(2);
      chk_pin({irq, wake}, 2'h0);
      wb(1'b1, cmp_ctrl_pkg::OFS_FLAGS, 32'h40);
      rchk(cmp_ctrl_pkg::OFS_FLAGS, 32'h40);
      chk_pin({irq, wake}, 2'h0);
      rchk(cmp_ctrl_pkg::OFS_CTRL1, 32'h98);
      sleep <= 1'b0;
      $display("interrupt test done");
      dir <= 2'h2;
      wb(1'b1, cmp_ctrl_pkg::OFS_CTRL1, 32'hC0);
      waitc(4);
      chk_pin(pin, 2'h1);
      chk_pin(oe, 2'h2);
      wb(1'b1, cmp_ctrl_pkg::OFS_CTRL1, 32'hE0);
      waitc(4);
      chk_pin(pin, 2'h3);
      wb(1'b1, 8'h40, 32'hFF);
      rchk(8'h40, 32'h0);
      wb(1'b1, cmp_ctrl_pkg::OFS_STATUS, 32'hFF);
      rchk(cmp_ctrl_pkg::OFS_STATUS, 32'h1);
      wb(1'b1, cmp_ctrl_pkg::OFS_CTRL1, 32'h80);
      wb(1'b1, cmp_ctrl_pkg::OFS_CTRL1, 32'h82);
      rchk(cmp_ctrl_pkg::OFS_CTRL1, 32'h80);
      rst_i <= 1'b1;
      waitc(1);
      rst_i <= 1'b0;
      waitc(1);
      rchk(cmp_ctrl_pkg::OFS_CTRL1, 32'h1F);
      wb(1'b1, cmp_ctrl_pkg::OFS_CTRL2, 32'h81);
      rchk(cmp_ctrl_pkg::OFS_CTRL2, 32'h81);
      chk_reg(rd_r, 32'h83);
      $display("pin and reset test done");
      stop_test();
   end
endmodule : tb_top
